// File: dcos_map.svh
// Register offsets, field positions, reset values and sizes for the DIO sequencer.
`ifndef DCOS_MAP_SVH
`define DCOS_MAP_SVH
`define DCOS_NLINES        8
`define DCOS_FIFO_AW       6
`define DCOS_FIFO_DEPTH    64
`define DCOS_FIFO_DEPTH_HI 32
`define DCOS_ADR_CD_CTRL   8'h00
`define DCOS_ADR_CD_WATCH  8'h04
`define DCOS_ADR_CD_RISE   8'h08
`define DCOS_ADR_CD_FALL   8'h0C
`define DCOS_ADR_CD_SAMPLE 8'h10
`define DCOS_ADR_CD_STAT   8'h14
`define DCOS_ADR_DO_CTRL   8'h18
`define DCOS_ADR_DO_COUNT  8'h1C
`define DCOS_ADR_DO_DATA   8'h20
`define DCOS_ADR_DO_SW     8'h24
`define DCOS_ADR_DO_STAT   8'h28
`define DCOS_ADR_DO_CMD    8'h2C
`define DCOS_ADR_DO_TASK   8'h30
`define DCOS_CD_EN_BIT     0
`define DCOS_CD_BUF_BIT    1
`define DCOS_DO_MODE_LSB   0
`define DCOS_DO_TRIG_LSB   4
`define DCOS_DO_CLKSRC_BIT 7
`define DCOS_DO_PAUSE_BIT  8
`define DCOS_DO_PPOL_BIT   9
`define DCOS_DO_HISLOT_BIT 10
`define DCOS_DO_DIV_LSB    16
`define DCOS_DO_CTRL_RST   32'h0001_0000
`define DCOS_CMD_START_BIT 0
`define DCOS_CMD_STOP_BIT  1
`define DCOS_CMD_SWTRG_BIT 2
`define DCOS_CMD_CLRUF_BIT 3
`define DCOS_CMD_WRAP_BIT  4
`define DCOS_RD_UNMAPPED   32'hDEAD_0000
`endif

// File: dcos_pkg.sv
// Types shared by the DIO change-detect and output sequencer.
package dcos_pkg;
  typedef enum logic [2:0] {
    DCOS_MODE_FINITE = 3'b000,
    DCOS_MODE_REGEN  = 3'b001,
    DCOS_MODE_OBREGEN = 3'b010,
    DCOS_MODE_NOREGEN = 3'b011
  } dcos_mode_t;
  typedef enum logic [1:0] {
    DCOS_TRG_SOFT = 2'b00,
    DCOS_TRG_DIG  = 2'b01,
    DCOS_TRG_ANA  = 2'b10,
    DCOS_TRG_TIME = 2'b11
  } dcos_trig_t;
  typedef enum logic [1:0] {
    DCOS_ST_IDLE = 2'b00,
    DCOS_ST_ARM  = 2'b01,
    DCOS_ST_RUN  = 2'b10
  } dcos_state_t;
endpackage

// File: dcos_top.sv
// DIO change detection acquisition and buffered digital output sequencer.
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "dcos_map.svh"
module dcos_top (
  input  wire logic        clk_i,        // System clock, 40 MHz.
  input  wire logic        rst_i,        // Synchronous reset, active high.
  input  wire logic        wb_cyc_i,     // Wishbone cycle.
  input  wire logic        wb_stb_i,     // Wishbone strobe.
  input  wire logic        wb_we_i,      // Wishbone write enable.
  input  wire logic [7:0]  wb_adr_i,     // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,     // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,     // Wishbone write data.
  output logic      [31:0] wb_dat_o,     // Wishbone read data.
  output logic             wb_ack_o,     // Wishbone acknowledge.
  input  wire logic [7:0]  din_i,        // Digital input lines from modules.
  input  wire logic        ext_clk_i,    // External sample clock pin.
  input  wire logic        dig_trig_i,   // Digital trigger from a terminal.
  input  wire logic        ana_trig_i,   // Analog comparison event.
  input  wire logic        time_trig_i,  // Time trigger pulse.
  output logic             line_change_event_o, // Change event pulse for terminals.
  output logic [7:0]       dout_o,       // Digital output lines.
  output logic             sample_clk_o  // Output update strobe.
);
  localparam int NL = `DCOS_NLINES;
  localparam int AW = `DCOS_FIFO_AW;

  // Three-stage synchronisers for pins; a change counts when stages two and three agree.
  logic [NL+3:0] s1_r, s2_r, s3_r, flt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      flt_r <= '0;
    end else begin
      s1_r <= {time_trig_i, ana_trig_i, dig_trig_i, ext_clk_i, din_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
      flt_r <= (s2_r & s3_r) | (flt_r & (s2_r | s3_r));
    end
  end
  logic [NL+3:0] prev_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) prev_r <= '0;
    else prev_r <= flt_r;
  end
  wire [NL-1:0] lines    = flt_r[NL-1:0];
  wire [NL-1:0] lines_q  = prev_r[NL-1:0];
  wire          ext_rise = flt_r[NL] & ~prev_r[NL];
  wire          dig_rise = flt_r[NL+1] & ~prev_r[NL+1];
  wire          dig_lvl  = flt_r[NL+1];
  wire          ana_rise = flt_r[NL+2] & ~prev_r[NL+2];
  wire          ana_lvl  = flt_r[NL+2];
  wire          tim_rise = flt_r[NL+3] & ~prev_r[NL+3];

  // Configuration registers.
  logic [1:0]    cd_ctrl_r;
  logic [NL-1:0] cd_watch_r, cd_rise_r, cd_fall_r, cd_sample_r;
  logic [31:0]   do_ctrl_r, do_count_r;
  logic [NL-1:0] do_sw_r;
  logic [3:0]    do_task_r;
  logic          cd_rdy_r, cd_ovf_r, uf_r, rej_r;

  wire wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr   = wb_req & wb_we_i;
  wire wb_rd   = wb_req & ~wb_we_i;
  wire [7:0] wr_b = wb_dat_i[7:0];
  wire b0 = wb_sel_i[0];

  dcos_pkg::dcos_mode_t mode;
  dcos_pkg::dcos_trig_t trig_src;
  assign mode     = dcos_pkg::dcos_mode_t'(do_ctrl_r[`DCOS_DO_MODE_LSB +: 3]);
  assign trig_src = dcos_pkg::dcos_trig_t'(do_ctrl_r[`DCOS_DO_TRIG_LSB +: 2]);
  wire        clk_ext   = do_ctrl_r[`DCOS_DO_CLKSRC_BIT];
  wire        pause_ana = do_ctrl_r[`DCOS_DO_PAUSE_BIT];
  wire        pause_pol = do_ctrl_r[`DCOS_DO_PPOL_BIT];
  wire        hi_slot   = do_ctrl_r[`DCOS_DO_HISLOT_BIT];
  wire [15:0] clk_div   = do_ctrl_r[`DCOS_DO_DIV_LSB +: 16];
  // Task word: bit0 module serial, bit1 hw task uses parallel, bit2 hw uses serial.
  wire        mod_serial = do_task_r[0];

  wire cmd_wr    = wb_wr && wb_adr_i == `DCOS_ADR_DO_CMD && b0;
  wire cmd_start = cmd_wr & wb_dat_i[`DCOS_CMD_START_BIT];
  wire cmd_stop  = cmd_wr & wb_dat_i[`DCOS_CMD_STOP_BIT];
  wire cmd_swtrg = cmd_wr & wb_dat_i[`DCOS_CMD_SWTRG_BIT];
  wire cmd_clruf = cmd_wr & wb_dat_i[`DCOS_CMD_CLRUF_BIT];
  wire cmd_wrap  = cmd_wr & wb_dat_i[`DCOS_CMD_WRAP_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cd_ctrl_r   <= '0;
      cd_watch_r  <= '0;
      cd_rise_r   <= '0;
      cd_fall_r   <= '0;
      cd_sample_r <= '0;
      do_ctrl_r   <= `DCOS_DO_CTRL_RST;
      do_count_r  <= '0;
      do_task_r   <= '0;
    end else if (wb_wr) begin
      case (wb_adr_i)
        `DCOS_ADR_CD_CTRL:   if (b0) cd_ctrl_r <= wr_b[1:0];
        `DCOS_ADR_CD_WATCH:  if (b0) cd_watch_r <= wr_b;
        `DCOS_ADR_CD_RISE:   if (b0) cd_rise_r <= wr_b;
        `DCOS_ADR_CD_FALL:   if (b0) cd_fall_r <= wr_b;
        `DCOS_ADR_CD_SAMPLE: if (b0) cd_sample_r <= wr_b;
        `DCOS_ADR_DO_CTRL: begin
          for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) do_ctrl_r[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
          end
        end
        `DCOS_ADR_DO_COUNT: begin
          for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) do_count_r[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
          end
        end
        `DCOS_ADR_DO_TASK:   if (b0) do_task_r <= wr_b[3:0];
        default: ;
      endcase
    end
  end

  // Change detection.
  wire [NL-1:0] edges = cd_watch_r & ((cd_rise_r & lines & ~lines_q) |
                                      (cd_fall_r & ~lines & lines_q));
  wire cd_hit = cd_ctrl_r[`DCOS_CD_EN_BIT] & (|edges);
  wire cd_buf = cd_ctrl_r[`DCOS_CD_BUF_BIT];
  wire [NL-1:0] cd_snap = lines & cd_sample_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) line_change_event_o <= 1'b0;
    else line_change_event_o <= cd_hit;
  end

  // Direct (nonbuffered) sample holding register.
  logic [NL-1:0] cd_data_r;
  wire cd_rd = wb_rd && wb_adr_i == `DCOS_ADR_CD_SAMPLE;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cd_data_r <= '0;
      cd_rdy_r  <= 1'b0;
      cd_ovf_r  <= 1'b0;
    end else begin
      if (cd_hit & ~cd_buf) cd_data_r <= cd_snap;
      if (cd_hit & ~cd_buf) cd_rdy_r <= 1'b1;
      else if (cd_rd) cd_rdy_r <= 1'b0;
      if (cd_hit & ~cd_buf & cd_rdy_r) cd_ovf_r <= 1'b1;
      else if (wb_wr && wb_adr_i == `DCOS_ADR_CD_STAT && b0 && wb_dat_i[1]) cd_ovf_r <= 1'b0;
    end
  end

  // Shared onboard FIFO: acquisition or output, chosen by which path is active.
  logic [NL-1:0] fifo_mem [0:(1<<AW)-1];
  logic [AW:0]   wp_r, rp_r, base_r;
  logic          loaded_r;
  dcos_pkg::dcos_state_t st_r;
  wire run = st_r == dcos_pkg::DCOS_ST_RUN;
  wire [AW:0] level = wp_r - rp_r;
  wire [AW:0] cap = hi_slot ? (AW+1)'(`DCOS_FIFO_DEPTH_HI)
                            : (AW+1)'(`DCOS_FIFO_DEPTH);
  wire fifo_full  = level >= cap;
  wire fifo_empty = level == '0;

  wire host_wr  = wb_wr && wb_adr_i == `DCOS_ADR_DO_DATA && b0;
  // A read of an empty FIFO is answered but leaves the pointer, so the level cannot wrap.
  wire fifo_rd  = wb_rd && wb_adr_i == `DCOS_ADR_DO_DATA && ~fifo_empty;
  // Onboard regeneration locks the FIFO against host data writes once the buffer is marked complete.
  wire do_push  = host_wr & ~fifo_full &
                  ~(mode == dcos_pkg::DCOS_MODE_OBREGEN & loaded_r);
  wire cd_push  = cd_hit & cd_buf & ~fifo_full;
  wire push     = do_push | cd_push;

  // Pacing: internal divider or external clock edge.
  logic [15:0] div_r;
  always_ff @(posedge clk_i) begin
    if (rst_i | ~run) div_r <= '0;
    else if (div_r >= clk_div) div_r <= '0;
    else div_r <= div_r + 16'h0001;
  end
  wire tick = run & (clk_ext ? ext_rise : (div_r >= clk_div));
  // Pause level sampled only at a tick, so a sample under way finishes.
  wire pause_src = pause_ana ? ana_lvl : dig_lvl;
  wire paused    = pause_src ^ pause_pol;
  wire upd       = tick & ~paused & ~fifo_empty;
  wire starve    = tick & ~paused & fifo_empty;
  wire regen     = mode == dcos_pkg::DCOS_MODE_REGEN | mode == dcos_pkg::DCOS_MODE_OBREGEN;
  wire pop       = upd | fifo_rd;

  logic [31:0] done_r;
  always_ff @(posedge clk_i) begin
    if (rst_i | cmd_start) done_r <= '0;
    else if (upd) done_r <= done_r + 32'h0000_0001;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r     <= '0;
      base_r   <= '0;
      loaded_r <= 1'b0;
    end else begin
      if (push) wp_r <= wp_r + (AW+1)'(1);
      if (cmd_wrap) base_r <= rp_r;
      if (cmd_wrap) loaded_r <= 1'b1;
      else if (st_r == dcos_pkg::DCOS_ST_IDLE & cmd_start) loaded_r <= loaded_r;
      else if (cmd_stop) loaded_r <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (push) fifo_mem[wp_r[AW-1:0]] <= cd_push ? cd_snap : wr_b;
  end
  // In the regeneration modes the read pointer rewinds to the buffer start when drained.
  always_ff @(posedge clk_i) begin
    if (rst_i) rp_r <= '0;
    else if (upd & regen & (rp_r + (AW+1)'(1) == wp_r)) rp_r <= base_r;
    else if (pop) rp_r <= rp_r + (AW+1)'(1);
  end

  // Generation state machine.
  wire trig_fire = (trig_src == dcos_pkg::DCOS_TRG_SOFT) ? cmd_swtrg :
                   (trig_src == dcos_pkg::DCOS_TRG_DIG)  ? dig_rise :
                   (trig_src == dcos_pkg::DCOS_TRG_ANA)  ? ana_rise : tim_rise;
  // A hardware task mixing parallel and serial modules is refused.
  wire mix_bad = do_task_r[1] & do_task_r[2];
  wire fin_done = mode == dcos_pkg::DCOS_MODE_FINITE && upd &&
                  done_r + 32'h0000_0001 >= do_count_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) st_r <= dcos_pkg::DCOS_ST_IDLE;
    else begin
      case (st_r)
        dcos_pkg::DCOS_ST_IDLE: if (cmd_start & ~mix_bad & ~uf_r) st_r <= dcos_pkg::DCOS_ST_ARM;
        dcos_pkg::DCOS_ST_ARM: begin
          if (cmd_stop) st_r <= dcos_pkg::DCOS_ST_IDLE;
          else if (trig_fire) st_r <= dcos_pkg::DCOS_ST_RUN;
        end
        dcos_pkg::DCOS_ST_RUN: begin
          if (cmd_stop | fin_done) st_r <= dcos_pkg::DCOS_ST_IDLE;
          else if (starve & mode == dcos_pkg::DCOS_MODE_NOREGEN) begin
            st_r <= dcos_pkg::DCOS_ST_IDLE;
          end
        end
        default: st_r <= dcos_pkg::DCOS_ST_IDLE;
      endcase
    end
  end
  // Underflow: set wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) uf_r <= 1'b0;
    else if (run & starve & mode == dcos_pkg::DCOS_MODE_NOREGEN) uf_r <= 1'b1;
    else if (cmd_clruf | cmd_start) uf_r <= 1'b0;
  end

  // Software-timed writes: one command per update, refused on a busy serial module.
  wire sw_wr  = wb_wr && wb_adr_i == `DCOS_ADR_DO_SW && b0;
  wire sw_bad = mod_serial & (st_r != dcos_pkg::DCOS_ST_IDLE);
  always_ff @(posedge clk_i) begin
    if (rst_i) rej_r <= 1'b0;
    else if (sw_wr & sw_bad) rej_r <= 1'b1;
    else if (cmd_start & mix_bad) rej_r <= 1'b1;
    else if (wb_wr && wb_adr_i == `DCOS_ADR_DO_STAT && b0 && wb_dat_i[1]) rej_r <= 1'b0;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_o  <= '0;
      do_sw_r <= '0;
      sample_clk_o <= 1'b0;
    end else begin
      sample_clk_o <= upd;
      if (upd) dout_o <= fifo_mem[rp_r[AW-1:0]];
      else if (sw_wr & ~sw_bad) dout_o <= wr_b;
      if (sw_wr & ~sw_bad) do_sw_r <= wr_b;
    end
  end

  // Wishbone read mux and single-cycle acknowledge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_rd) begin
        case (wb_adr_i)
          `DCOS_ADR_CD_CTRL:   wb_dat_o <= {30'h0, cd_ctrl_r};
          `DCOS_ADR_CD_WATCH:  wb_dat_o <= {24'h0, cd_watch_r};
          `DCOS_ADR_CD_RISE:   wb_dat_o <= {24'h0, cd_rise_r};
          `DCOS_ADR_CD_FALL:   wb_dat_o <= {24'h0, cd_fall_r};
          `DCOS_ADR_CD_SAMPLE: wb_dat_o <= {24'h0, cd_data_r};
          `DCOS_ADR_CD_STAT:   wb_dat_o <= {30'h0, cd_ovf_r, cd_rdy_r};
          `DCOS_ADR_DO_CTRL:   wb_dat_o <= do_ctrl_r;
          `DCOS_ADR_DO_COUNT:  wb_dat_o <= do_count_r;
          `DCOS_ADR_DO_DATA:   wb_dat_o <= {24'h0, fifo_mem[rp_r[AW-1:0]]};
          `DCOS_ADR_DO_SW:     wb_dat_o <= {24'h0, do_sw_r};
          `DCOS_ADR_DO_STAT:   wb_dat_o <= {18'h0, level, fifo_full, fifo_empty,
                                            loaded_r, st_r, rej_r, uf_r};
          `DCOS_ADR_DO_CMD:    wb_dat_o <= done_r;
          `DCOS_ADR_DO_TASK:   wb_dat_o <= {28'h0, do_task_r};
          default:             wb_dat_o <= `DCOS_RD_UNMAPPED;
        endcase
      end
    end
  end

  // Assertions.
  chg_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cd_hit |=> line_change_event_o)
    else $error("change event missing");
  chg_snap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cd_hit & ~cd_buf) |=> cd_rdy_r && cd_data_r == $past(cd_snap))
    else $error("direct sample wrong");
  uf_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (run & starve & mode == dcos_pkg::DCOS_MODE_NOREGEN & ~cmd_stop) |=> uf_r && !run)
    else $error("underflow not halted");
  uf_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (uf_r & ~cmd_clruf & ~cmd_start) |=> uf_r)
    else $error("underflow flag lost");
  finite_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fin_done & ~cmd_stop |=> st_r == dcos_pkg::DCOS_ST_IDLE)
    else $error("finite did not stop");
  pause_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick & paused) |=> !sample_clk_o)
    else $error("update during pause");
  serial_rej_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sw_wr & sw_bad) |=> rej_r && $stable(do_sw_r))
    else $error("serial write not refused");
  mix_rej_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_start & mix_bad & st_r == dcos_pkg::DCOS_ST_IDLE) |=> st_r == dcos_pkg::DCOS_ST_IDLE)
    else $error("mixed task started");
  slot_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (hi_slot & push) |-> level < (AW+1)'(`DCOS_FIFO_DEPTH_HI))
    else $error("fifo cap wrong");
  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
endmodule

// File: dcos_dio_model.sv
// Behavioural model of the plug-in digital modules on the far side of the sequencer.
`timescale 1ns/1ps
module dcos_dio_model (
  input  wire logic        clk_i,     // System clock.
  input  wire logic        rst_i,     // Synchronous reset, active high.
  input  wire logic [7:0]  level_i,   // Line levels the bench asks the input module for.
  output logic      [7:0]  din_o,     // Input lines toward the sequencer.
  input  wire logic        event_i,   // Change event pulse from the sequencer.
  input  wire logic        upd_i,     // Output update strobe from the sequencer.
  input  wire logic [7:0]  dout_i,    // Output lines from the sequencer.
  output logic      [15:0] ev_cnt_o,  // Change events seen so far.
  output logic      [15:0] upd_cnt_o, // Output updates latched so far.
  output logic      [7:0]  last_o     // Value latched at the latest update.
);
  // Lines change just after an edge, as a real module's drivers would.
  always_ff @(posedge clk_i) begin
    din_o <= level_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_cnt_o <= 16'h0000;
    end else if (event_i) begin
      ev_cnt_o <= ev_cnt_o + 16'h0001;
    end
  end

  // The output module latches only on the update strobe, never between strobes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd_cnt_o <= 16'h0000;
      last_o    <= 8'h00;
    end else if (upd_i) begin
      upd_cnt_o <= upd_cnt_o + 16'h0001;
      last_o    <= dout_i;
    end
  end
endmodule

// File: tb.sv
// Self-checking testbench for the DIO change-detect and output sequencer.
`timescale 1ns/1ps
`include "dcos_map.svh"
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  din_i;
  logic [7:0]  level = 8'h00;
  logic        ext_clk_i = 1'b0;
  logic [2:0]  trg = 3'h0;
  logic        line_change_event_o;
  logic [7:0]  dout_o;
  logic        sample_clk_o;
  logic [15:0] ev_cnt;
  logic [15:0] upd_cnt;
  logic [7:0]  last;
  logic [31:0] d;
  logic [15:0] base;
  int          error_cnt = 0;
  int          comparisons = 0;

  always #12.5 clk_i = ~clk_i;

  dcos_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .din_i(din_i), .ext_clk_i(ext_clk_i),
    .dig_trig_i(trg[0]), .ana_trig_i(trg[1]), .time_trig_i(trg[2]),
    .line_change_event_o(line_change_event_o), .dout_o(dout_o), .sample_clk_o(sample_clk_o));

  dcos_dio_model mdl (.clk_i(clk_i), .rst_i(rst_i), .level_i(level), .din_o(din_i),
    .event_i(line_change_event_o), .upd_i(sample_clk_o), .dout_i(dout_o),
    .ev_cnt_o(ev_cnt), .upd_cnt_o(upd_cnt), .last_o(last));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; holds the request until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      $display("unexpected at %0t: bus timeout", $time);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    wb(1'b1, a, v, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    wb(1'b0, a, 32'h0000_0000, v);
  endtask

  task automatic wait_upd(input logic [15:0] n);
    for (int i = 0; i < 400 && upd_cnt - base < n; i++) @(posedge clk_i);
    repeat (20) @(posedge clk_i);
  endtask

  task automatic t_change();
    wr(`DCOS_ADR_CD_WATCH, 32'h0000_0080);
    wr(`DCOS_ADR_CD_RISE, 32'h0000_0080);
    wr(`DCOS_ADR_CD_FALL, 32'h0000_0000);
    wr(`DCOS_ADR_CD_SAMPLE, 32'h0000_000F);
    wr(`DCOS_ADR_CD_CTRL, 32'h0000_0001);
    base = ev_cnt;
    level <= 8'h85;
    repeat (20) @(posedge clk_i);
    chk(ev_cnt - base, 1);
    rd(`DCOS_ADR_CD_SAMPLE, d);
    chk(d[7:0], 8'h05);
    level <= 8'h05;
    repeat (20) @(posedge clk_i);
    chk(ev_cnt - base, 1);
    wr(`DCOS_ADR_CD_CTRL, 32'h0000_0003);
    level <= 8'h8A;
    repeat (20) @(posedge clk_i);
    chk(ev_cnt - base, 2);
    rd(`DCOS_ADR_DO_DATA, d);
    chk(d[7:0], 8'h0A);
    wr(`DCOS_ADR_CD_CTRL, 32'h0000_0000);
  endtask

  // Long enough high and low for the three-stage synchroniser to pass each level.
  task automatic ext_pulse();
    ext_clk_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    ext_clk_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic t_sw();
    base = upd_cnt;
    wr(`DCOS_ADR_DO_SW, 32'h0000_005A);
    repeat (2) @(posedge clk_i);
    chk(dout_o, 8'h5A);
    chk(upd_cnt - base, 16'h0000);
    rd(`DCOS_ADR_DO_SW, d);
    chk(d[7:0], 8'h5A);
  endtask

  task automatic t_finite();
    wr(`DCOS_ADR_DO_CTRL, 32'h0003_0000);
    wr(`DCOS_ADR_DO_COUNT, 32'h0000_0003);
    wr(`DCOS_ADR_DO_DATA, 32'h0000_0011);
    wr(`DCOS_ADR_DO_DATA, 32'h0000_0022);
    wr(`DCOS_ADR_DO_DATA, 32'h0000_0033);
    wr(`DCOS_ADR_DO_DATA, 32'h0000_0044);
    base = upd_cnt;
    wr(`DCOS_ADR_DO_CMD, 32'h0000_0001);
    wr(`DCOS_ADR_DO_CMD, 32'h0000_0004);
    wait_upd(3);
    chk(upd_cnt - base, 16'h0003);
    chk(last, 8'h33);
    rd(`DCOS_ADR_DO_CMD, d);
    chk(d, 32'h0000_0003);
    rd(`DCOS_ADR_DO_STAT, d);
    chk(d[3:2], 2'h0);
    rd(`DCOS_ADR_DO_DATA, d);
    chk(d[7:0], 8'h44);
  endtask

  task automatic t_noregen();
    wr(`DCOS_ADR_DO_CTRL, 32'h0003_0033);
    wr(`DCOS_ADR_DO_DATA, 32'h0000_0021);
    wr(`DCOS_ADR_DO_DATA, 32'h0000_0042);
    base = upd_cnt;
    wr(`DCOS_ADR_DO_CMD, 32'h0000_0001);
    trg[2] <= 1'b1;
    repeat (6) @(posedge clk_i);
    trg[2] <= 1'b0;
    wait_upd(2);
    chk(upd_cnt - base, 16'h0002);
    chk(last, 8'h42);
    rd(`DCOS_ADR_DO_STAT, d);
    chk(d[3:0], 4'h1);
    wr(`DCOS_ADR_DO_CMD, 32'h0000_0008);
    rd(`DCOS_ADR_DO_STAT, d);
    chk(d[0], 1'b0);
  endtask

  task automatic t_regen();
    wr(`DCOS_ADR_DO_CTRL, 32'h0001_0082);
    wr(`DCOS_ADR_DO_DATA, 32'h0000_0001);
    wr(`DCOS_ADR_DO_DATA, 32'h0000_0002);
    wr(`DCOS_ADR_DO_CMD, 32'h0000_0010);
    wr(`DCOS_ADR_DO_DATA, 32'h0000_0003);
    base = upd_cnt;
    wr(`DCOS_ADR_DO_CMD, 32'h0000_0001);
    wr(`DCOS_ADR_DO_CMD, 32'h0000_0004);
    ext_pulse();
    ext_pulse();
    trg[0] <= 1'b1;
    repeat (6) @(posedge clk_i);
    ext_pulse();
    chk(upd_cnt - base, 16'h0002);
    trg[0] <= 1'b0;
    repeat (6) @(posedge clk_i);
    ext_pulse();
    chk(upd_cnt - base, 16'h0003);
    chk(last, 8'h01);
    wr(`DCOS_ADR_DO_TASK, 32'h0000_0001);
    wr(`DCOS_ADR_DO_SW, 32'h0000_0077);
    rd(`DCOS_ADR_DO_STAT, d);
    chk(d[3:1], 3'h5);
    chk(dout_o, 8'h01);
    wr(`DCOS_ADR_DO_STAT, 32'h0000_0002);
    wr(`DCOS_ADR_DO_CMD, 32'h0000_0002);
    rd(`DCOS_ADR_DO_STAT, d);
    chk(d[3:2], 2'h0);
    wr(`DCOS_ADR_DO_TASK, 32'h0000_0006);
    wr(`DCOS_ADR_DO_CMD, 32'h0000_0001);
    rd(`DCOS_ADR_DO_STAT, d);
    chk(d[3:1], 3'h1);
    wr(`DCOS_ADR_DO_STAT, 32'h0000_0002);
    wr(`DCOS_ADR_DO_TASK, 32'h0000_0000);
    rd(`DCOS_ADR_DO_STAT, d);
    chk(d[13:7], 7'h01);
    rd(`DCOS_ADR_DO_DATA, d);
    chk(d[7:0], 8'h02);
  endtask

  task automatic t_slot();
    wr(`DCOS_ADR_DO_CTRL, 32'h0001_0400);
    for (int i = 0; i < 34; i++) wr(`DCOS_ADR_DO_DATA, i);
    rd(`DCOS_ADR_DO_STAT, d);
    chk(d[13:6], 8'h41);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_change();
    t_sw();
    t_finite();
    t_noregen();
    t_regen();
    t_slot();
    end_sim();
  end

  initial begin
    #400_000;
    error_cnt++;
    end_sim();
  end

  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
endmodule
